//--- design/adit_pkg.sv
// Constants, state codes and helper functions of the ATA DMA data-in timing block.
// Assumes the pin-facing logic runs on a link clock of LINK_PERIOD_PS.
package adit_pkg;

    // Data path
    localparam int DATA_W = 16;
    localparam int CNT_W = 4;

    // Link clock that paces the pin-facing logic
    localparam int LINK_PERIOD_PS = 125000;

    // Ultra DMA mode tables, indexed by mode 0..4
    localparam int MODE_N = 5;
    localparam logic [7:0] MODE_SUPPORTED = 8'h17;
    localparam int T_DZFS_PS [MODE_N] = '{70000, 48000, 31000, 20000, 6700};
    localparam int T_CYC_PS [MODE_N] = '{112000, 73000, 54000, 39000, 25000};
    localparam int T_SS_PS = 50000;
    localparam int T_MLI_PS = 20000;

    // Least time in ps to whole link cycles, never below one
    function automatic int adit_cyc_min(input int t_ps);
        int n;
        n = (t_ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
        return (n < 1) ? 1 : n;
    endfunction : adit_cyc_min

    // Counter loads derived from the times above
    localparam logic [CNT_W-1:0] DZFS_CYC [MODE_N] = '{
        CNT_W'(adit_cyc_min(T_DZFS_PS[0])), CNT_W'(adit_cyc_min(T_DZFS_PS[1])),
        CNT_W'(adit_cyc_min(T_DZFS_PS[2])), CNT_W'(adit_cyc_min(T_DZFS_PS[3])),
        CNT_W'(adit_cyc_min(T_DZFS_PS[4]))};
    localparam logic [CNT_W-1:0] CYC_CYC [MODE_N] = '{
        CNT_W'(adit_cyc_min(T_CYC_PS[0])), CNT_W'(adit_cyc_min(T_CYC_PS[1])),
        CNT_W'(adit_cyc_min(T_CYC_PS[2])), CNT_W'(adit_cyc_min(T_CYC_PS[3])),
        CNT_W'(adit_cyc_min(T_CYC_PS[4]))};
    localparam logic [CNT_W-1:0] SS_CYC = CNT_W'(adit_cyc_min(T_SS_PS));
    localparam logic [CNT_W-1:0] MLI_CYC = CNT_W'(adit_cyc_min(T_MLI_PS));

    // Strobe levels and CRC
    localparam logic STROBE_IDLE = 1'b0;
    localparam logic STROBE_FINAL = 1'b1;
    localparam logic [DATA_W-1:0] CRC_POLY = 16'h1021;
    localparam logic [DATA_W-1:0] CRC_SEED = 16'h4aba;

    // Link state machine
    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_MW    = 10'h002,
        ST_UREQ  = 10'h004,
        ST_UWAIT = 10'h008,
        ST_UDZFS = 10'h010,
        ST_UXFER = 10'h020,
        ST_USTOP = 10'h040,
        ST_UREL  = 10'h080,
        ST_UFIN  = 10'h100,
        ST_UCRC  = 10'h200
    } adit_state_t;

    // One data word folded into the running CRC, msb first
    function automatic logic [DATA_W-1:0] adit_crc_step(input logic [DATA_W-1:0] crc,
                                                        input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] c;
        c = crc;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            c = (c[DATA_W-1] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : adit_crc_step

endpackage : adit_pkg

//--- design/adit_sync.sv
// Two-stage synchroniser for a group of level signals.
// Assumes each bit is a level or toggle that holds for at least two destination cycles.
`timescale 1ns/1ns
module adit_sync #(
    parameter int W = 1
)(
    // Destination clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule : adit_sync

//--- design/adit_core.sv
// Device-side timing and handshake of ATA DMA data-in: Multiword DMA and Ultra DMA bursts.
// Assumes user words arrive on mclk_i, the ATA pins are handled on link_clk_i, and the
// outside world resolves the shared wires from the output enables.
`timescale 1ns/1ns

// Behaviour
// - Multiword DMA reads follow mode 2 handshake
// - DMARQ updated right after each strobe edge
// - Data drivers off once DMACK negates
// - Ultra modes 0,1,2,4 select timing
// - Strobe driven only after DMACK seen
// - Wait tDZFS after driving data, then strobe
// - Host pause stops strobe toggling
// - Release data drivers when burst ends
// - Interlock wait before final strobe step
// - Wait tSS after last strobe, drop DMARQ
// - Release strobe pin after DMACK negates
// - New word for every strobe edge
// - Device pauses strobe without data ready
module adit_core
    import adit_pkg::*;
(
    // Clocks and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic link_clk_i,
    // User control, mclk domain
    input wire logic udma_en_i,
    input wire logic [2:0] udma_mode_i,
    input wire logic xfer_en_i,
    input wire logic end_burst_i,
    // User word stream, mclk domain
    input wire logic [DATA_W-1:0] word_data_i,
    input wire logic word_valid_i,
    output logic word_ready_o,
    // Burst result, mclk domain
    output logic crc_done_o,
    output logic crc_err_o,
    // ATA pins from the host
    input wire logic dmack_n_i,
    input wire logic dior_n_i,
    input wire logic diow_n_i,
    input wire logic [DATA_W-1:0] dd_i,
    // ATA pins driven by the device
    output logic [DATA_W-1:0] dd_o,
    output logic dd_oe_o,
    output logic dmarq_o,
    output logic iordy_o,
    output logic iordy_oe_o
);

    // ---------------- mclk domain ----------------
    logic [DATA_W-1:0] hold_data;
    logic hold_full;
    logic req_tgl;
    logic ack_seen;
    logic done_seen;
    logic [2:0] res_s;
    logic ack_tgl;
    logic done_tgl;
    logic crc_err_l;

    // Word handover decode
    wire ack_s = res_s[0];
    wire done_s = res_s[1];
    wire err_s = res_s[2];
    wire hold_take = word_valid_i && !hold_full;
    wire hold_free = hold_full && (ack_s != ack_seen);
    wire next_hold_full = hold_take || (hold_full && !hold_free);

    // Holding register; request toggles toward the link side
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_data <= '0;
            hold_full <= 1'b0;
            req_tgl <= 1'b0;
            ack_seen <= 1'b0;
            word_ready_o <= 1'b0;
        end else begin
            if (hold_take) begin
                hold_data <= word_data_i;
                req_tgl <= ~req_tgl;
            end
            hold_full <= next_hold_full;
            ack_seen <= ack_s;
            word_ready_o <= !next_hold_full;
        end
    end

    // Burst result back from the link side
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_seen <= 1'b0;
            crc_done_o <= 1'b0;
            crc_err_o <= 1'b0;
        end else begin
            done_seen <= done_s;
            crc_done_o <= done_s != done_seen;
            if (done_s != done_seen) begin
                crc_err_o <= err_s;
            end
        end
    end

    adit_sync #(.W(3)) u_res_sync (
        .clk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i({crc_err_l, done_tgl, ack_tgl}),
        .q_o(res_s)
    );

    // ---------------- link domain ----------------
    logic [6:0] ctl_s;
    logic [DATA_W+2:0] pin_s;
    logic req_seen;
    logic [DATA_W-1:0] word_reg;
    logic word_full;
    logic dior_n_q;
    logic pend;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] crc;
    adit_state_t st;

    adit_sync #(.W(7)) u_ctl_sync (
        .clk_i(link_clk_i),
        .resetn_i(resetn_i),
        .d_i({end_burst_i, xfer_en_i, udma_mode_i, udma_en_i, req_tgl}),
        .q_o(ctl_s)
    );

    adit_sync #(.W(DATA_W + 3)) u_pin_sync (
        .clk_i(link_clk_i),
        .resetn_i(resetn_i),
        .d_i({dd_i, diow_n_i, dior_n_i, dmack_n_i}),
        .q_o(pin_s)
    );

    // Control and pin decode
    wire req_s = ctl_s[0];
    wire udma_s = ctl_s[1];
    wire [2:0] mode_s = ctl_s[4:2];
    wire xfer_s = ctl_s[5];
    wire end_s = ctl_s[6];
    wire dmack = !pin_s[0];
    wire dior_n_s = pin_s[1];
    wire stop = pin_s[2];
    wire [DATA_W-1:0] dd_s = pin_s[DATA_W+2:3];
    wire hdmardy = !dior_n_s;
    wire dior_rise = dior_n_s && !dior_n_q;

    // Mode table selection; unsupported modes fall back to the slowest
    wire [2:0] mode_idx = MODE_SUPPORTED[mode_s] ? mode_s : 3'h0;
    wire [CNT_W-1:0] dzfs_load = DZFS_CYC[mode_idx];
    wire [CNT_W-1:0] cyc_load = CYC_CYC[mode_idx];
    wire cnt_zero = cnt == '0;

    // Data-path decode
    wire word_new = req_s != req_seen;
    wire want = xfer_s && word_full;
    wire u_run = (st == ST_UXFER) && !stop && !end_s && xfer_s;
    wire mw_take = (st == ST_MW) && dmack && dior_rise && word_full;
    wire u_edge = pend && hdmardy && cnt_zero && ((st == ST_UDZFS) || u_run);
    wire u_load = u_run && cnt_zero && !pend && word_full;
    wire word_take = mw_take || u_edge;
    wire word_load = word_new && (!word_full || word_take);
    wire u_body = (st == ST_UWAIT) || (st == ST_UDZFS) || (st == ST_UXFER) ||
                  (st == ST_USTOP) || (st == ST_UREL) || (st == ST_UFIN);
    wire u_abort = u_body && !dmack;

    // Word register fed from the holding register; ack frees the next word
    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_seen <= 1'b0;
            word_reg <= '0;
            word_full <= 1'b0;
            ack_tgl <= 1'b0;
            dior_n_q <= 1'b1;
        end else begin
            if (word_load) begin
                word_reg <= hold_data;
                req_seen <= req_s;
                ack_tgl <= ~ack_tgl;
            end
            word_full <= word_load || (word_full && !word_take);
            dior_n_q <= dior_n_s;
        end
    end

    // Link state machine: request, strobe, termination and CRC check
    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= ST_IDLE;
            dmarq_o <= 1'b0;
            dd_o <= '0;
            dd_oe_o <= 1'b0;
            iordy_o <= STROBE_IDLE;
            iordy_oe_o <= 1'b0;
            cnt <= '0;
            pend <= 1'b0;
            crc <= CRC_SEED;
            crc_err_l <= 1'b0;
            done_tgl <= 1'b0;
        end else begin
            if (!cnt_zero) begin
                cnt <= cnt - 4'h1;
            end
            // Each strobe edge carries the word on the bus
            if (u_edge) begin
                iordy_o <= ~iordy_o;
                pend <= 1'b0;
                cnt <= cyc_load;
                crc <= adit_crc_step(crc, dd_o);
            end
            if (u_abort) begin
                st <= ST_IDLE;
                dmarq_o <= 1'b0;
                dd_oe_o <= 1'b0;
                iordy_oe_o <= 1'b0;
                pend <= 1'b0;
            end else begin
                unique case (st)
                    ST_IDLE: begin
                        crc <= CRC_SEED;
                        iordy_oe_o <= 1'b0;
                        dd_oe_o <= 1'b0;
                        if (want) begin
                            dmarq_o <= 1'b1;
                            st <= udma_s ? ST_UREQ : ST_MW;
                        end
                    end
                    ST_MW: begin
                        dd_o <= word_reg;
                        dd_oe_o <= dmack && !dior_n_s;
                        if (dmack && dior_rise) begin
                            dmarq_o <= xfer_s && word_new;
                        end else if (dior_n_s && !dmarq_o && want) begin
                            dmarq_o <= 1'b1;
                        end else if (!dmack && !xfer_s) begin
                            dmarq_o <= 1'b0;
                        end
                        if (!dmack && !dmarq_o) begin
                            st <= ST_IDLE;
                        end
                    end
                    ST_UREQ: begin
                        if (dmack) begin
                            iordy_oe_o <= 1'b1;
                            iordy_o <= STROBE_IDLE;
                            st <= ST_UWAIT;
                        end else if (!xfer_s) begin
                            dmarq_o <= 1'b0;
                            st <= ST_IDLE;
                        end
                    end
                    ST_UWAIT: begin
                        if (!stop && hdmardy && word_full) begin
                            dd_o <= word_reg;
                            dd_oe_o <= 1'b1;
                            pend <= 1'b1;
                            cnt <= dzfs_load;
                            st <= ST_UDZFS;
                        end
                    end
                    ST_UDZFS: begin
                        if (u_edge) begin
                            st <= ST_UXFER;
                        end
                    end
                    ST_UXFER: begin
                        if (stop || end_s || !xfer_s) begin
                            pend <= 1'b0;
                            cnt <= SS_CYC;
                            st <= ST_USTOP;
                        end else if (u_load) begin
                            dd_o <= word_reg;
                            pend <= 1'b1;
                        end
                    end
                    ST_USTOP: begin
                        if (cnt_zero) begin
                            dmarq_o <= 1'b0;
                            st <= ST_UREL;
                        end
                    end
                    ST_UREL: begin
                        if (stop && !hdmardy) begin
                            dd_oe_o <= 1'b0;
                            cnt <= MLI_CYC;
                            st <= ST_UFIN;
                        end
                    end
                    ST_UFIN: begin
                        if (cnt_zero) begin
                            iordy_o <= STROBE_FINAL;
                            st <= ST_UCRC;
                        end
                    end
                    ST_UCRC: begin
                        if (!dmack) begin
                            crc_err_l <= dd_s != crc;
                            done_tgl <= ~done_tgl;
                            iordy_oe_o <= 1'b0;
                            st <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

endmodule : adit_core

//--- test/adit_core_properties.sv
// Pin timing checker for adit_core, on the link clock.
// Assumes host pins pass two link flops inside the core.
`timescale 1ns/1ns
module adit_core_properties
    import adit_pkg::*;
(
    // Link clock and reset
    input wire logic link_clk_i,
    input wire logic resetn_i,
    // Pins
    input wire logic dmack_n_i,
    input wire logic dior_n_i,
    input wire logic [DATA_W-1:0] dd_o,
    input wire logic dd_oe_o,
    input wire logic dmarq_o,
    input wire logic iordy_o,
    input wire logic iordy_oe_o
);
    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (!resetn_i);
    // Strobe pin and data bus ownership
    strobe_after_ack_a: assert property ($rose(iordy_oe_o) |-> !$past(dmack_n_i))
        else $error("strobe driven before ack");
    strobe_release_a: assert property ($rose(dmack_n_i) |-> ##[1:4] !iordy_oe_o)
        else $error("strobe pin held after ack");
    bus_release_a: assert property (dmack_n_i [*4] |-> !dd_oe_o)
        else $error("bus held after ack");
    // Strobe edges against data and handshake
    pause_hold_a: assert property (dior_n_i [*4] ##1 dd_oe_o |-> $stable(iordy_o))
        else $error("strobe moved while paused");
    first_strobe_a: assert property ($changed(iordy_o) && dd_oe_o |-> $past(dd_oe_o) && $past(dd_oe_o, 2))
        else $error("strobe too soon after bus on");
    data_setup_a: assert property ($changed(iordy_o) && dd_oe_o |-> $stable(dd_o))
        else $error("data moved at strobe");
    stop_gap_a: assert property ($fell(dmarq_o) && iordy_oe_o
        |-> $past(iordy_o) == iordy_o && $past(iordy_o, 2) == iordy_o)
        else $error("request dropped too soon");
    final_gap_a: assert property ($changed(iordy_o) && iordy_oe_o && !dd_oe_o
        |-> !$past(dd_oe_o) && !$past(dd_oe_o, 2))
        else $error("final strobe too soon");
endmodule : adit_core_properties

bind adit_core adit_core_properties u_props (.link_clk_i, .resetn_i, .dmack_n_i, .dior_n_i, .dd_o,
    .dd_oe_o, .dmarq_o, .iordy_o, .iordy_oe_o);

//--- test/adit_host_model.sv
// Host adapter model: DMACK, strobes, STOP, HDMARDY and CRC word.
// Assumes the bench calls its tasks and reads gotq and mw_rq.
`timescale 1ns/1ns
module adit_host_model
    import adit_pkg::*;
(
    // Link clock and device pins
    input wire logic link_clk_i,
    input wire logic [DATA_W-1:0] dd_o,
    input wire logic dd_oe_o,
    input wire logic dmarq_o,
    input wire logic iordy_o,
    input wire logic iordy_oe_o,
    // Host pins
    output logic dmack_n_o = 1'b1,
    output logic dior_n_o = 1'b1,
    output logic diow_n_o = 1'b1,
    output logic [DATA_W-1:0] dd_bus_o
);
    logic [DATA_W-1:0] hdd = 16'h0;
    logic hoe = 1'b0;
    logic pat = 1'b0;
    logic strb = 1'b0;
    logic mw_rq;
    logic [DATA_W-1:0] gotq[$];
    // Released bus flips every cycle
    always @(posedge link_clk_i) pat <= ~pat;
    assign dd_bus_o = dd_oe_o ? dd_o : (hoe ? hdd : {DATA_W{pat}});
    // Latch a word on each strobe edge; flag a bus fight
    always @(negedge link_clk_i) begin
        if (iordy_oe_o && dd_oe_o && iordy_o !== strb) gotq.push_back(dd_bus_o);
        if (dd_oe_o && hoe) tb_adit_core.tmo();
        strb = iordy_o;
    end
    // Host CRC over latched words
    function automatic logic [DATA_W-1:0] host_crc();
        logic [DATA_W-1:0] c;
        c = CRC_SEED;
        foreach (gotq[k])
            for (int i = DATA_W - 1; i >= 0; i--)
                c = (c[DATA_W-1] ^ gotq[k][i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        return c;
    endfunction : host_crc
    // Bounded wait: 0 request, 1 bus off, 2 final strobe
    task automatic wait_pin(input int sel);
        int n;
        for (n = 0; n < 2000; n++) begin
            if (sel == 0 ? dmarq_o === 1'b1 : sel == 1 ? dd_oe_o === 1'b0 : iordy_o === STROBE_FINAL) break;
            @(negedge link_clk_i);
        end
        if (n == 2000) tb_adit_core.tmo();
    endtask : wait_pin
    // Multiword reads, 500 ns per strobe phase
    task automatic mw_read(input int cnt);
        gotq.delete();
        wait_pin(0);
        dmack_n_o = 1'b0;
        for (int k = 0; k < cnt; k++) begin
            wait_pin(0);
            dior_n_o = 1'b0;
            repeat (4) @(negedge link_clk_i);
            gotq.push_back(dd_bus_o);
            dior_n_o = 1'b1;
            repeat (4) @(negedge link_clk_i);
        end
        mw_rq = dmarq_o;
        dmack_n_o = 1'b1;
    endtask : mw_read
    // Ultra data-in burst; stop_at 0 lets the device end it
    task automatic ultra_read(input int stop_at, input logic bad);
        int n;
        gotq.delete();
        wait_pin(0);
        repeat (2) @(negedge link_clk_i);
        dmack_n_o = 1'b0;
        repeat (4) @(negedge link_clk_i);
        diow_n_o = 1'b0;
        dior_n_o = 1'b0;
        for (n = 0; n < 2000 && dmarq_o === 1'b1 && (stop_at == 0 || gotq.size() < stop_at); n++)
            @(negedge link_clk_i);
        if (n == 2000) tb_adit_core.tmo();
        dior_n_o = 1'b1;
        repeat (6) @(negedge link_clk_i);
        diow_n_o = 1'b1;
        wait_pin(1);
        repeat (2) @(negedge link_clk_i);
        hdd = host_crc() ^ {15'h0, bad};
        hoe = 1'b1;
        wait_pin(2);
        repeat (2) @(negedge link_clk_i);
        dmack_n_o = 1'b1;
        repeat (4) @(negedge link_clk_i);
        hoe = 1'b0;
    endtask : ultra_read
endmodule : adit_host_model

//--- test/tb_adit_core.sv
// Bench for adit_core: word stream, Multiword and Ultra DMA data-in.
// Assumes the host model drives the pins and keeps latched words.
`timescale 1ns/1ns
module tb_adit_core
    import adit_pkg::*;
();
    logic mclk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic udma_en_i = 1'b0;
    logic [2:0] udma_mode_i = 3'h0;
    logic xfer_en_i = 1'b0;
    logic end_burst_i = 1'b0;
    logic [DATA_W-1:0] word_data_i = 16'h8001;
    logic word_valid_i = 1'b0;
    logic word_ready_o, crc_done_o, crc_err_o, dmack_n_i, dior_n_i, diow_n_i;
    logic dd_oe_o, dmarq_o, iordy_o, iordy_oe_o, taken, last_err;
    logic [DATA_W-1:0] dd_i, dd_o;
    logic [DATA_W-1:0] expq[$];
    int mismatches = 0;
    int compares = 0;
    int feed = 0;
    int dones = 0;
    // Clocks
    initial forever #25 mclk_i = ~mclk_i;
    initial begin
        #7;
        forever begin
            #62 link_clk_i = 1'b1;
            #63 link_clk_i = 1'b0;
        end
    end
    adit_core u_dut (.mclk_i, .resetn_i, .link_clk_i, .udma_en_i, .udma_mode_i, .xfer_en_i, .end_burst_i,
        .word_data_i, .word_valid_i, .word_ready_o, .crc_done_o, .crc_err_o, .dmack_n_i, .dior_n_i,
        .diow_n_i, .dd_i, .dd_o, .dd_oe_o, .dmarq_o, .iordy_o, .iordy_oe_o);
    adit_host_model u_host (.link_clk_i, .dd_o, .dd_oe_o, .dmarq_o, .iordy_o, .iordy_oe_o,
        .dmack_n_o(dmack_n_i), .dior_n_o(dior_n_i), .diow_n_o(diow_n_i), .dd_bus_o(dd_i));
    // Record taken words and finished bursts
    always @(posedge mclk_i) begin
        taken = word_valid_i && word_ready_o === 1'b1;
        if (taken) expq.push_back(word_data_i);
        if (crc_done_o === 1'b1) begin
            dones++;
            last_err = crc_err_o;
        end
    end
    // Offer the next word while feed lasts
    always @(negedge mclk_i) begin
        if (taken) begin
            word_data_i = word_data_i + 16'h1357;
            feed--;
        end
        taken = 1'b0;
        word_valid_i = feed > 0;
    end
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_words();
        foreach (u_host.gotq[k]) chk(u_host.gotq[k], expq.pop_front(), "word");
    endtask : chk_words
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic tmo();
        mismatches++;
        $display("CHECK FAILED %0t wait or bus fight", $time);
        wrap_up();
    endtask : tmo
    // Multiword read of three words
    task automatic t_mw();
        feed = 3;
        xfer_en_i = 1'b1;
        u_host.mw_read(3);
        chk_words();
        chk(16'(u_host.mw_rq), 16'h0, "request after last");
        repeat (10) @(negedge mclk_i);
        chk(16'(dd_oe_o), 16'h0, "bus released");
        xfer_en_i = 1'b0;
    endtask : t_mw
    // Ultra burst; how: 0 device drops xfer, 1 end request, 2 host stop
    task automatic t_ultra(input logic [2:0] m, input int how, input logic bad);
        int d;
        int n;
        d = dones;
        udma_mode_i = m;
        udma_en_i = 1'b1;
        feed = 40;
        xfer_en_i = 1'b1;
        // Clear last burst's words first, so the watcher branch cannot see a stale count
        u_host.gotq.delete();
        fork
            u_host.ultra_read(how == 2 ? 4 : 0, bad);
            begin
                for (n = 0; n < 4000 && u_host.gotq.size() < 4; n++) @(negedge mclk_i);
                if (n == 4000) tmo();
                if (how == 0) xfer_en_i = 1'b0;
                if (how == 1) end_burst_i = 1'b1;
            end
        join
        for (n = 0; n < 100 && dones == d; n++) @(negedge mclk_i);
        if (n == 100) tmo();
        end_burst_i = 1'b0;
        if (how != 2) xfer_en_i = 1'b0;
        chk(16'(dones - d), 16'h1, "one result");
        chk(16'(last_err), 16'(bad), "crc verdict");
        chk_words();
    endtask : t_ultra
    // Reset, then the scenarios
    initial begin
        repeat (4) @(negedge mclk_i);
        chk(16'({dd_oe_o, dmarq_o, iordy_oe_o, word_ready_o}), 16'h0, "reset outputs");
        resetn_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(16'(word_ready_o), 16'h1, "ready after reset");
        t_mw();
        t_ultra(3'h0, 0, 1'b0);
        t_ultra(3'h1, 0, 1'b0);
        t_ultra(3'h2, 1, 1'b1);
        t_ultra(3'h3, 1, 1'b0);
        t_ultra(3'h4, 2, 1'b0);
        wrap_up();
    end
endmodule : tb_adit_core
